// >>> verilog/sfrd_pkg.sv
package sfrd_pkg;
	localparam logic [7:0] SFRD_SFR_BASE = 8'h80;
	localparam logic [7:0] SFRD_EMC_ADDR = 8'h85;
	localparam logic [7:0] SFRD_PSEL_ADDR = 8'haa;
	localparam int SFRD_FAE_BIT = 6;
	localparam int SFRD_PG_W = 5;
	localparam logic [5:0] SFRD_EMC_FIXED = 6'h03;
	localparam logic SFRD_FAE_RST = 1'b0;
	localparam logic [4:0] SFRD_PG_RST = 5'h00;
	localparam logic [2:0] SFRD_BITADDR_LOW = 3'h0;
	localparam logic [15:0] SFRD_FIFO_LO = 16'h0400;
	localparam logic [15:0] SFRD_FIFO_HI = 16'h07ff;
	localparam logic [7:0] SFRD_FREE0 = 8'hab;
	localparam logic [7:0] SFRD_FREE1 = 8'had;
	localparam logic [7:0] SFRD_FREE2 = 8'hbf;
	localparam logic [7:0] SFRD_FREE3 = 8'hce;
	localparam logic [7:0] SFRD_FREE4 = 8'hdf;

	typedef struct packed {
		logic [7:0] addr;
		logic we;
		logic bitop;
		logic [2:0] bitpos;
		logic [7:0] wdata;
	} sfrd_dir_t;

	typedef struct packed {
		logic wide;
		logic [15:0] addr;
		logic we;
		logic [7:0] wdata;
	} sfrd_xm_t;

	typedef struct packed {
		logic [15:0] addr;
		logic we;
		logic [7:0] wdata;
	} sfrd_mem_t;
endpackage

// >>> verilog/sfrd_xsteer.sv
`timescale 1ns/1ps
module sfrd_xsteer (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic xm_req,
	input wire sfrd_pkg::sfrd_xm_t xm,
	input wire logic fae,
	input wire logic [sfrd_pkg::SFRD_PG_W-1:0] page,
	output logic xram_req_q,
	output logic fifo_req_q,
	output sfrd_pkg::sfrd_mem_t mem_q
);
	import sfrd_pkg::*;

	wire [15:0] full_addr;
	wire in_window;
	wire to_fifo;

	// short operand takes its high byte from the page register
	assign full_addr = xm.wide ? xm.addr : {{(8-SFRD_PG_W){1'b0}}, page, xm.addr[7:0]}; // [R11]
	assign in_window = (full_addr >= SFRD_FIFO_LO) && (full_addr <= SFRD_FIFO_HI);
	// fifo replaces xram in the window only while enabled
	assign to_fifo = fae && in_window; // [R1] [R2] [R12]

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			xram_req_q <= 1'b0;
			fifo_req_q <= 1'b0;
			mem_q <= '0;
		end else begin
			xram_req_q <= xm_req && !to_fifo;
			fifo_req_q <= xm_req && to_fifo;
			if (xm_req) begin
				mem_q <= '{addr: full_addr, we: xm.we, wdata: xm.wdata};
			end
		end
	end

	AST_FIFO_NEEDS_FAE: assert property (@(posedge mclk) disable iff (!nrst) // [R1]
		fifo_req_q |-> $past(fae)) else $error("fifo reached while access enable clear");
	AST_FIFO_WINDOW: assert property (@(posedge mclk) disable iff (!nrst) // [R2]
		(xm_req && fae && in_window) |=> (fifo_req_q && !xram_req_q && mem_q.addr[15:10] == 6'h01))
		else $error("window access not steered to fifo");
	AST_XRAM_HIDDEN: assert property (@(posedge mclk) disable iff (!nrst) // [R12]
		xram_req_q |-> !($past(fae) && mem_q.addr >= SFRD_FIFO_LO && mem_q.addr <= SFRD_FIFO_HI))
		else $error("xram reached inside fifo window");
	AST_PAGE_HIGH: assert property (@(posedge mclk) disable iff (!nrst) // [R11]
		(xm_req && !xm.wide) |=> mem_q.addr[15:8] == {3'h0, $past(page)})
		else $error("short operand high byte not from page");
	COV_FIFO: cover property (@(posedge mclk) disable iff (!nrst) fifo_req_q);
	COV_PAGED: cover property (@(posedge mclk) disable iff (!nrst) xm_req && !xm.wide && page != 5'h00);
endmodule

// >>> verilog/sfrd_core.sv
`timescale 1ns/1ps
// How it works
// R1: with fifo access enable clear, no external move reaches the fifo ram.
// R2: with enable set, fifo ram appears at 0x0400 to 0x07ff.
// R3: software uses the fifo window only with usb clock at least twice system clock.
// R4: config register at 0x85; bit 6 is writable enable, resets to 0.
// R5: config bit 7 reads 0; writes to it are ignored.
// R6: config bits 5..0 read 000011b; writes have no effect.
// R7: direct access to 0x80..0xff goes to the register space, not data ram.
// R8: addresses ending 0x0 or 0x8 allow bit operations; others byte only.
// R9: software avoids unoccupied register addresses.
// R10: page select register decoded at 0xaa.
// R11: short-operand external move takes high address byte from page select.
// R12: with enable set, xram in the fifo window is unreachable.
// R13: unoccupied addresses read zero and discard writes.
module sfrd_core (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic dir_req,
	input wire sfrd_pkg::sfrd_dir_t dir,
	output logic iram_sel,
	output logic per_req,
	input wire logic [7:0] per_rdata,
	output logic rd_valid_q,
	output logic [7:0] rdata_q,
	output logic bit_refused_q,
	input wire logic xm_req,
	input wire sfrd_pkg::sfrd_xm_t xm,
	output logic xram_req_q,
	output logic fifo_req_q,
	output sfrd_pkg::sfrd_mem_t mem_q,
	output logic fifo_access_enable
);
	import sfrd_pkg::*;

	function automatic logic sfrd_occupied(input logic [7:0] a);
		sfrd_occupied = a[7] && a != SFRD_FREE0 && a != SFRD_FREE1 && a != SFRD_FREE2
			&& a != SFRD_FREE3 && a != SFRD_FREE4;
	endfunction

	logic fae_q;
	logic [SFRD_PG_W-1:0] pg_q;
	logic [7:0] rdata_d;

	wire is_sfr;
	wire bit_ok;
	wire bit_bad;
	wire hit_emc;
	wire hit_psel;
	wire occupied;
	wire wr_emc;
	wire wr_psel;
	wire [7:0] emc_view;
	wire [7:0] psel_view;

	// upper half of direct space is register space
	assign is_sfr = dir.addr[7]; // [R7]
	assign iram_sel = dir_req && !is_sfr; // [R7]
	assign bit_ok = dir.addr[2:0] == SFRD_BITADDR_LOW; // [R8]
	assign bit_bad = dir_req && is_sfr && dir.bitop && !bit_ok; // [R8]
	assign hit_emc = dir.addr == SFRD_EMC_ADDR; // [R4]
	assign hit_psel = dir.addr == SFRD_PSEL_ADDR; // [R10]
	assign occupied = sfrd_occupied(dir.addr); // [R13]
	// own registers are not bit-addressable, so bit operations on them are refused
	assign wr_emc = dir_req && dir.we && !dir.bitop && hit_emc; // [R4] [R8]
	assign wr_psel = dir_req && dir.we && !dir.bitop && hit_psel; // [R10] [R8]
	assign per_req = dir_req && occupied && !hit_emc && !hit_psel && !bit_bad; // [R13] [R8]
	assign emc_view = {1'b0, fae_q, SFRD_EMC_FIXED}; // [R5] [R6]
	assign psel_view = {{(8-SFRD_PG_W){1'b0}}, pg_q};
	assign fifo_access_enable = fae_q;

	always_comb begin
		rdata_d = 8'h00; // [R13]
		if (hit_emc) begin
			rdata_d = emc_view;
		end else if (hit_psel) begin
			rdata_d = psel_view;
		end else if (occupied && !bit_bad) begin
			rdata_d = per_rdata;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fae_q <= SFRD_FAE_RST; // [R4]
			pg_q <= SFRD_PG_RST;
		end else begin
			if (wr_emc) begin
				fae_q <= dir.wdata[SFRD_FAE_BIT]; // [R4] [R5] [R6]
			end
			if (wr_psel) begin
				pg_q <= dir.wdata[SFRD_PG_W-1:0]; // [R10]
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rd_valid_q <= 1'b0;
			rdata_q <= 8'h00;
			bit_refused_q <= 1'b0;
		end else begin
			rd_valid_q <= dir_req && is_sfr && !dir.we;
			bit_refused_q <= bit_bad; // [R8]
			if (dir_req && is_sfr && !dir.we) begin
				rdata_q <= rdata_d;
			end
		end
	end

	sfrd_xsteer u_xsteer (
		.mclk(mclk),
		.nrst(nrst),
		.xm_req(xm_req),
		.xm(xm),
		.fae(fae_q),
		.page(pg_q),
		.xram_req_q(xram_req_q),
		.fifo_req_q(fifo_req_q),
		.mem_q(mem_q)
	);

	AST_SFR_NOT_IRAM: assert property (@(posedge mclk) disable iff (!nrst) // [R7]
		(dir_req && dir.addr >= SFRD_SFR_BASE) |-> !iram_sel) else $error("register access sent to data ram");
	AST_EMC_READ: assert property (@(posedge mclk) disable iff (!nrst) // [R5]
		(dir_req && !dir.we && hit_emc) |=> (rd_valid_q && rdata_q[7] == 1'b0 && rdata_q[6] == fae_q))
		else $error("config bit 7 or enable misread");
	AST_EMC_FIXED: assert property (@(posedge mclk) disable iff (!nrst) // [R6]
		(dir_req && !dir.we && hit_emc) |=> rdata_q[5:0] == 6'b000011) else $error("config low bits wrong");
	AST_FAE_WRITE: assert property (@(posedge mclk) disable iff (!nrst) // [R4]
		(dir_req && dir.we && !dir.bitop && hit_emc) |=> fae_q == $past(dir.wdata[6]))
		else $error("enable bit not written");
	AST_PSEL_WRITE: assert property (@(posedge mclk) disable iff (!nrst) // [R10]
		(dir_req && dir.we && !dir.bitop && hit_psel) ##1 (dir_req && !dir.we && hit_psel)
		|=> rdata_q == {3'h0, $past(dir.wdata[4:0], 2)}) else $error("page select readback wrong");
	AST_FREE_ZERO: assert property (@(posedge mclk) disable iff (!nrst) // [R13]
		(dir_req && !dir.we && is_sfr && !occupied) |=> (rdata_q == 8'h00 && !$past(per_req)))
		else $error("unoccupied address not zero");
	AST_BIT_REFUSE: assert property (@(posedge mclk) disable iff (!nrst) // [R8]
		(dir_req && is_sfr && dir.bitop) |=> bit_refused_q == ($past(dir.addr[2:0]) != 3'h0))
		else $error("bit operation acceptance wrong");
	AST_FAE_RESET: assert property (@(posedge mclk) // [R4]
		$rose(nrst) |-> !fae_q) else $error("enable not zero after reset");
	AST_IRAM_LOW: assert property (@(posedge mclk) disable iff (!nrst) // [R7]
		(dir_req && !dir.addr[7]) |-> (iram_sel && !per_req))
		else $error("data ram access sent to register space");
	AST_OWN_NO_PER: assert property (@(posedge mclk) disable iff (!nrst) // [R4] [R10]
		(dir_req && (hit_emc || hit_psel)) |-> !per_req)
		else $error("own register access passed to peripherals");
	AST_BITOP_NO_WRITE: assert property (@(posedge mclk) disable iff (!nrst) // [R8]
		(dir_req && dir.we && dir.bitop && (hit_emc || hit_psel)) |=> ($stable(fae_q) && $stable(pg_q)))
		else $error("refused bit operation changed a register");
	AST_PSEL_TOP_ZERO: assert property (@(posedge mclk) disable iff (!nrst) // [R10]
		(dir_req && !dir.we && hit_psel) |=> rdata_q[7:5] == 3'h0)
		else $error("page select top bits not zero");
	COV_FAE_SET: cover property (@(posedge mclk) disable iff (!nrst) $rose(fae_q));
	COV_BIT_OP: cover property (@(posedge mclk) disable iff (!nrst) dir_req && dir.bitop && bit_ok && per_req);
	COV_FREE_READ: cover property (@(posedge mclk) disable iff (!nrst) dir_req && is_sfr && !occupied);
endmodule

// >>> test/sfrd_per_model.sv
`timescale 1ns/1ps
module sfrd_per_model (
	input wire logic mclk,
	input wire logic per_req,
	input wire sfrd_pkg::sfrd_dir_t dir,
	output logic [7:0] per_rdata
);
	import sfrd_pkg::*;
	logic [7:0] noise_q = 8'h00;
	// the peripheral side is only ever asked for occupied addresses
	// unselected read data changes every cycle
	always @(posedge mclk) noise_q <= ~noise_q;
	assign per_rdata = per_req ? (dir.addr ^ 8'h5a) : noise_q;
endmodule

// >>> test/sfrd_core_tb.sv
`timescale 1ns/1ps
module sfrd_core_tb;
	import sfrd_pkg::*;
	typedef struct packed {logic [7:0] a; logic we; logic bo; logic [7:0] wd; logic [7:0] ex;} sfrd_row_t;
	typedef struct packed {logic w; logic [15:0] a; logic [15:0] ea; logic f;} sfrd_xrow_t;
	logic mclk = 0, nrst = 0, dir_req = 0, xm_req = 0;
	sfrd_dir_t dir = '0;
	sfrd_xm_t xm = '0;
	logic iram_sel, per_req, rd_valid_q, bit_refused_q, xram_req_q, fifo_req_q, fifo_access_enable;
	logic [7:0] per_rdata, rdata_q;
	sfrd_mem_t mem_q;
	int mismatches = 0, num_checks = 0, cycles = 0;
	sfrd_row_t rows [17] = '{'{8'h85,0,0,0,8'h03}, '{8'h85,1,0,8'hff,0}, '{8'h85,0,0,0,8'h43},
		'{8'h85,1,1,8'h00,0}, '{8'h85,0,0,0,8'h43}, '{8'h85,1,0,8'h80,0}, '{8'h85,0,0,0,8'h03},
		'{8'haa,0,0,0,8'h00}, '{8'haa,1,0,8'hff,0}, '{8'haa,0,0,0,8'h1f}, '{8'hab,1,0,8'hff,0},
		'{8'hab,0,0,0,8'h00}, '{8'h85,0,1,0,8'h03}, '{8'h88,0,1,0,8'hd2}, '{8'h7f,0,0,0,8'h00},
		'{8'haa,1,0,8'h05,0}, '{8'h85,1,0,8'h40,0}};
	sfrd_xrow_t xrows [6] = '{'{1,16'h0400,16'h0400,1}, '{1,16'h07ff,16'h07ff,1}, '{1,16'h03ff,16'h03ff,0},
		'{1,16'h0800,16'h0800,0}, '{0,16'h0010,16'h0510,1}, '{0,16'hff07,16'h0507,1}};
	sfrd_core dut (
		.mclk(mclk), .nrst(nrst), .dir_req(dir_req), .dir(dir), .iram_sel(iram_sel), .per_req(per_req),
		.per_rdata(per_rdata), .rd_valid_q(rd_valid_q), .rdata_q(rdata_q), .bit_refused_q(bit_refused_q),
		.xm_req(xm_req), .xm(xm), .xram_req_q(xram_req_q), .fifo_req_q(fifo_req_q), .mem_q(mem_q),
		.fifo_access_enable(fifo_access_enable)
	);
	sfrd_per_model per (.mclk(mclk), .per_req(per_req), .dir(dir), .per_rdata(per_rdata));
	initial begin
		forever #10 mclk = ~mclk;
	end
	task results;
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			results();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic own_or_free(input logic [7:0] a);
		return a inside {SFRD_EMC_ADDR, SFRD_PSEL_ADDR, SFRD_FREE0, SFRD_FREE1, SFRD_FREE2, SFRD_FREE3, SFRD_FREE4};
	endfunction
	task dacc(input logic [7:0] a, input logic we, input logic bo, input logic [7:0] wd, input logic [7:0] ex);
		@(posedge mclk);
		dir_req <= 1'b1;
		dir <= '{addr: a, we: we, bitop: bo, bitpos: 3'h0, wdata: wd};
		#1;
		chk(iram_sel, a < 8'h80);
		chk(per_req, a >= 8'h80 && !own_or_free(a) && !(bo && a[2:0] != 3'h0));
		@(posedge mclk);
		dir_req <= 1'b0;
		#1;
		chk(bit_refused_q, bo && a[2:0] != 3'h0);
		chk(rd_valid_q, !we && a >= 8'h80);
		if (!we && a >= 8'h80) chk(rdata_q, ex);
	endtask
	// window accesses assume the usb clock runs at least twice the system clock; no usb clock is modelled here
	task xacc(input logic w, input logic [15:0] a, input logic [15:0] ea, input logic f);
		@(posedge mclk);
		xm_req <= 1'b1;
		xm <= '{wide: w, addr: a, we: 1'b1, wdata: a[7:0]};
		@(posedge mclk);
		xm_req <= 1'b0;
		#1;
		chk(fifo_req_q, f);
		chk(xram_req_q, !f);
		chk(mem_q, {ea, 1'b1, a[7:0]});
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		for (int i = 0; i < 17; i++) dacc(rows[i].a, rows[i].we, rows[i].bo, rows[i].wd, rows[i].ex);
		chk(fifo_access_enable, 1'b1);
		for (int i = 0; i < 6; i++) xacc(xrows[i].w, xrows[i].a, xrows[i].ea, xrows[i].f);
		dacc(8'haa, 1, 0, 8'h04, 0);
		xacc(0, 16'h0033, 16'h0433, 1);
		dacc(8'h85, 1, 0, 8'h00, 0);
		xacc(1, 16'h0400, 16'h0400, 0);
		xacc(0, 16'h0044, 16'h0444, 0);
		dacc(8'h85, 1, 0, 8'h40, 0);
		@(posedge mclk);
		dir_req <= 1'b1;
		dir <= '{addr: SFRD_PSEL_ADDR, we: 1'b1, bitop: 1'b0, bitpos: 3'h0, wdata: 8'hfe};
		@(posedge mclk);
		dir <= '{addr: SFRD_PSEL_ADDR, we: 1'b0, bitop: 1'b0, bitpos: 3'h0, wdata: 8'h00};
		@(posedge mclk);
		dir_req <= 1'b0;
		#1;
		chk(rdata_q, 8'h1e);
		chk(rd_valid_q, 1'b1);
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(fifo_access_enable, 1'b0);
		chk(mem_q, 25'h0);
		nrst <= 1'b1;
		dacc(8'h85, 0, 0, 0, 8'h03);
		dacc(8'haa, 0, 0, 0, 8'h00);
		results();
	end
endmodule
